// File: rtl/cse_pkg.sv
// shared types and constants for the channel stop and ending block
package cse_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned STROBE_DELAY_NS = 220;
  localparam int unsigned STROBE_DELAY_CYC =
    (STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DLY_W = 5;

  // widths and reset values
  localparam int unsigned BUS_W = 8;
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam logic [1:0] COND_RST = 2'h0;
  localparam int unsigned COND_STOPPED_BIT = 0;
  localparam int unsigned COND_ADAPTER_END_BIT = 1;

  // inbound tags from the adapter
  typedef struct packed {
    logic status_in_tag;
    logic service_in;
    logic inbound_data_tag;
    logic operational_in;
  } cse_tag_in_s;

  // outbound tags to the adapter
  typedef struct packed {
    logic command_out;
    logic service_out;
    logic select_out;
    logic retain_out_tag;
  } cse_tag_out_s;

  localparam cse_tag_in_s TAG_IN_RST = '{default: 1'b0};
  localparam cse_tag_out_s TAG_OUT_RST = '{default: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER,
    ST_STOP,
    ST_WAIT_STAT,
    ST_DELAY,
    ST_READ,
    ST_ACCEPT,
    ST_POLL
  } cse_state_e;

endpackage : cse_pkg

// File: rtl/cse_ending.sv
// channel side of the stop indication and ending sequence
// Operation
// - stop answers service request with command_out
// - service_in and inbound_data_tag both low, channel drops command_out
// - status rise: slice request, 220 ns strobe
// - strobe loads reg a, reg b if flagged
// - confirm status tag, read status and condition
// - accept status by raising service_out
// - accept drops select_out and retain_out_tag
// - slice request when status_in_tag falls
// - poll operational_in low, drop service_out
`timescale 1ns/1ns
module cse_ending
  import cse_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // processor side
  input wire logic transfer_start_i,
  input wire logic stop_req_i,
  input wire logic hardware_transfer_flag_i,
  // adapter pins
  input wire cse_tag_in_s tag_in_i,
  input wire logic [BUS_W-1:0] bus_in_i,
  // outbound tags
  output cse_tag_out_s tag_out_o,
  // processor status
  output logic processor_slice_request_o,
  output logic bus_in_strobe_pulse_o,
  output logic [BUS_W-1:0] bus_in_holding_reg_a_o,
  output logic [BUS_W-1:0] bus_in_holding_reg_b_o,
  output cse_tag_in_s tag_in_lines_o,
  output logic [1:0] channel_condition_reg_o,
  output logic ending_done_o
);

  ////////////////////////////////////////////////////////////////////////////
  cse_tag_in_s sync1_r, sync1_nxt, tag_r, tag_nxt, prev_r, prev_nxt;
  logic [BUS_W-1:0] bsync1_r, bsync1_nxt, bus_r, bus_nxt;
  cse_state_e state_r, state_nxt;
  cse_tag_out_s out_r, out_nxt;
  logic [DLY_W-1:0] dly_r, dly_nxt;
  logic slice_r, slice_nxt, strobe_r, strobe_nxt, done_r, done_nxt;
  logic [BUS_W-1:0] hra_r, hra_nxt, hrb_r, hrb_nxt;
  logic [1:0] cond_r, cond_nxt;
  logic stat_rise, stat_fall, req_in;

  assign stat_rise = tag_r.status_in_tag & ~prev_r.status_in_tag;
  assign stat_fall = ~tag_r.status_in_tag & prev_r.status_in_tag;
  assign req_in = tag_r.service_in | tag_r.inbound_data_tag;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sync1_nxt = tag_in_i;
    tag_nxt = sync1_r;
    prev_nxt = tag_r;
    bsync1_nxt = bus_in_i;
    bus_nxt = bsync1_r;
    state_nxt = state_r;
    out_nxt = out_r;
    dly_nxt = dly_r;
    slice_nxt = 1'b0;
    strobe_nxt = 1'b0;
    done_nxt = 1'b0;
    hra_nxt = hra_r;
    hrb_nxt = hrb_r;
    cond_nxt = cond_r;
    unique case (state_r)
      ST_IDLE: begin
        if (transfer_start_i) begin
          out_nxt = '{command_out: 1'b0, service_out: 1'b0,
                     select_out: 1'b1, retain_out_tag: 1'b1};
          cond_nxt = COND_RST;
          state_nxt = ST_XFER;
        end
      end
      ST_XFER: begin
        if (stat_rise) begin
          // adapter ended the transfer on its own
          cond_nxt[COND_ADAPTER_END_BIT] = 1'b1;
          slice_nxt = 1'b1;
          dly_nxt = DLY_W'(STROBE_DELAY_CYC - 1);
          state_nxt = ST_DELAY;
        end else if (req_in && stop_req_i) begin
          out_nxt.command_out = 1'b1;
          state_nxt = ST_STOP;
        end
      end
      ST_STOP: begin
        // no byte moves while command_out stands
        if (!req_in) begin
          out_nxt.command_out = 1'b0;
          cond_nxt[COND_STOPPED_BIT] = 1'b1;
          state_nxt = ST_WAIT_STAT;
        end
      end
      ST_WAIT_STAT: begin
        if (stat_rise) begin
          slice_nxt = 1'b1;
          dly_nxt = DLY_W'(STROBE_DELAY_CYC - 1);
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_r != '0) begin
          dly_nxt = dly_r - 1'b1;
        end else begin
          strobe_nxt = 1'b1;
          hra_nxt = bus_r;
          if (hardware_transfer_flag_i) begin
            hrb_nxt = bus_r;
          end
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        // status byte read with channel end set by adapter
        if (tag_r.status_in_tag) begin
          out_nxt.service_out = 1'b1;
          out_nxt.select_out = 1'b0;
          out_nxt.retain_out_tag = 1'b0;
          state_nxt = ST_ACCEPT;
        end else begin
          state_nxt = ST_WAIT_STAT;
        end
      end
      ST_ACCEPT: begin
        if (stat_fall) begin
          slice_nxt = 1'b1;
          state_nxt = ST_POLL;
        end
      end
      ST_POLL: begin
        if (!tag_r.operational_in) begin
          out_nxt.service_out = 1'b0;
          done_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= TAG_IN_RST;
      tag_r <= TAG_IN_RST;
      prev_r <= TAG_IN_RST;
      bsync1_r <= HOLD_RST;
      bus_r <= HOLD_RST;
      state_r <= ST_IDLE;
      out_r <= TAG_OUT_RST;
      dly_r <= '0;
      slice_r <= 1'b0;
      strobe_r <= 1'b0;
      done_r <= 1'b0;
      hra_r <= HOLD_RST;
      hrb_r <= HOLD_RST;
      cond_r <= COND_RST;
    end else begin
      sync1_r <= sync1_nxt;
      tag_r <= tag_nxt;
      prev_r <= prev_nxt;
      bsync1_r <= bsync1_nxt;
      bus_r <= bus_nxt;
      state_r <= state_nxt;
      out_r <= out_nxt;
      dly_r <= dly_nxt;
      slice_r <= slice_nxt;
      strobe_r <= strobe_nxt;
      done_r <= done_nxt;
      hra_r <= hra_nxt;
      hrb_r <= hrb_nxt;
      cond_r <= cond_nxt;
    end
  end

  assign tag_out_o = out_r;
  assign processor_slice_request_o = slice_r;
  assign bus_in_strobe_pulse_o = strobe_r;
  assign bus_in_holding_reg_a_o = hra_r;
  assign bus_in_holding_reg_b_o = hrb_r;
  assign tag_in_lines_o = tag_r;
  assign channel_condition_reg_o = cond_r;
  assign ending_done_o = done_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_stop_req;
    state_r == ST_XFER && !stat_rise && req_in && stop_req_i;
  endsequence

  sequence s_status_rise;
    (state_r == ST_WAIT_STAT || state_r == ST_XFER) && stat_rise;
  endsequence

  property p_stop_cmd;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_stop_req |=> tag_out_o.command_out && !tag_out_o.service_out;
  endproperty
  a_stop_cmd: assert property (p_stop_cmd) else $error("stop did not raise command");

  property p_cmd_drop;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_r == ST_STOP && !req_in |=> !tag_out_o.command_out;
  endproperty
  a_cmd_drop: assert property (p_cmd_drop) else $error("command_out held");

  property p_cmd_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      tag_out_o.command_out && req_in |=> tag_out_o.command_out;
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command_out fell early");

  property p_strobe_delay;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_status_rise |=> processor_slice_request_o ##11 bus_in_strobe_pulse_o;
  endproperty
  a_strobe_delay: assert property (p_strobe_delay) else $error("strobe delay wrong");

  property p_no_early_strobe;
    @(posedge clk_i) disable iff (!reset_n_i)
      bus_in_strobe_pulse_o |-> $past(processor_slice_request_o, 11);
  endproperty
  a_no_early_strobe: assert property (p_no_early_strobe) else $error("strobe early");

  property p_load_a;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_r == ST_DELAY && dly_r == '0 |=> bus_in_holding_reg_a_o == $past(bus_r);
  endproperty
  a_load_a: assert property (p_load_a) else $error("reg a not loaded");

  property p_load_b;
    @(posedge clk_i) disable iff (!reset_n_i)
      bus_in_strobe_pulse_o && !$past(hardware_transfer_flag_i)
        |-> $stable(bus_in_holding_reg_b_o);
  endproperty
  a_load_b: assert property (p_load_b) else $error("reg b loaded unflagged");

  property p_accept;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(tag_out_o.service_out) |->
        !tag_out_o.select_out && !tag_out_o.retain_out_tag && !tag_out_o.command_out;
  endproperty
  a_accept: assert property (p_accept) else $error("accept without deselect");

  property p_fall_slice;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_r == ST_ACCEPT && stat_fall |=> processor_slice_request_o;
  endproperty
  a_fall_slice: assert property (p_fall_slice) else $error("no slice on status fall");

  property p_end;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_r == ST_POLL && !tag_r.operational_in |=> !tag_out_o.service_out && ending_done_o;
  endproperty
  a_end: assert property (p_end) else $error("service_out not dropped");

  property p_svc_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      tag_out_o.service_out && tag_r.operational_in |=> tag_out_o.service_out;
  endproperty
  a_svc_hold: assert property (p_svc_hold) else $error("service_out fell early");

endmodule : cse_ending

// File: dv/cse_adapter_model.sv
// adapter side model for the stop and ending sequence
`timescale 1ns/1ns
module cse_adapter_model
  import cse_pkg::*;
#(
  parameter logic [7:0] CH_END = 8'h04
)(
  // clock
  input wire logic clk_i,
  // bench control
  input wire logic go_i,
  input wire logic self_end_i,
  input wire logic data_tag_i,
  input wire logic [3:0] dly_i,
  input wire logic [7:0] stat_i,
  // interface pins
  input wire cse_tag_out_s tag_out_i,
  output cse_tag_in_s tag_in_o,
  output logic [BUS_W-1:0] bus_in_o
);
  task automatic pause();
    repeat (dly_i + 4'h1) @(posedge clk_i);
  endtask : pause

  initial begin
    tag_in_o = TAG_IN_RST;
    bus_in_o = 8'hA5;
    forever begin
      @(posedge clk_i);
      // released bus toggles
      bus_in_o <= ~bus_in_o;
      if (go_i) begin
        tag_in_o.operational_in <= 1'b1;
        if (!self_end_i) begin
          pause();
          if (data_tag_i) tag_in_o.inbound_data_tag <= 1'b1;
          else tag_in_o.service_in <= 1'b1;
          do @(posedge clk_i); while (!tag_out_i.command_out);
          pause();
          if (data_tag_i) tag_in_o.inbound_data_tag <= 1'b0;
          else tag_in_o.service_in <= 1'b0;
          do @(posedge clk_i); while (tag_out_i.command_out);
        end
        pause();
        bus_in_o <= stat_i | CH_END;
        tag_in_o.status_in_tag <= 1'b1;
        do @(posedge clk_i); while (!tag_out_i.service_out || tag_out_i.retain_out_tag);
        pause();
        tag_in_o.status_in_tag <= 1'b0;
        bus_in_o <= ~bus_in_o;
        pause();
        tag_in_o.operational_in <= 1'b0;
      end
    end
  end
endmodule : cse_adapter_model

// File: dv/channel_stop_and_ending_sequence_tb_top.sv
// self-checking bench for the stop and ending sequence
`timescale 1ns/1ns
module channel_stop_and_ending_sequence_tb_top;
  import cse_pkg::*;
  localparam logic [7:0] CH_END = 8'h04;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic transfer_start_i = 1'b0;
  logic stop_req_i = 1'b0;
  logic hardware_transfer_flag_i = 1'b0;
  logic go = 1'b0;
  logic self_end = 1'b0;
  logic data_tag = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [7:0] stat = 8'h00;
  logic [7:0] exp_b = HOLD_RST;
  cse_tag_in_s tag_in;
  cse_tag_in_s lines;
  cse_tag_out_s tag_out;
  logic [BUS_W-1:0] bus_in;
  logic [BUS_W-1:0] reg_a;
  logic [BUS_W-1:0] reg_b;
  logic slice;
  logic strobe;
  logic done;
  logic [1:0] cond;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  cse_ending uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .transfer_start_i(transfer_start_i),
    .stop_req_i(stop_req_i), .hardware_transfer_flag_i(hardware_transfer_flag_i),
    .tag_in_i(tag_in), .bus_in_i(bus_in), .tag_out_o(tag_out),
    .processor_slice_request_o(slice), .bus_in_strobe_pulse_o(strobe),
    .bus_in_holding_reg_a_o(reg_a), .bus_in_holding_reg_b_o(reg_b),
    .tag_in_lines_o(lines), .channel_condition_reg_o(cond), .ending_done_o(done));

  cse_adapter_model #(.CH_END(CH_END)) model (.clk_i(clk_i), .go_i(go),
    .self_end_i(self_end), .data_tag_i(data_tag), .dly_i(dly), .stat_i(stat),
    .tag_out_i(tag_out),
    .tag_in_o(tag_in), .bus_in_o(bus_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      close_out();
    end
  end

  // bounded wait on one design output
  task automatic wait_on(input int sel, input logic lvl, output int n);
    logic v;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      case (sel)
        0: v = tag_out.command_out;
        1: v = slice;
        2: v = strobe;
        3: v = tag_out.service_out;
        default: v = done;
      endcase
    end while (v !== lvl && n < 100);
    if (n >= 100) check(8'h00, 8'h01);
  endtask : wait_on

  ////////////////////////////////////////////////////////////////////////
  task automatic run_ending(input logic self_e, input logic flag, input logic [3:0] d,
                            input logic [7:0] s, input logic dt);
    int n;
    @(posedge clk_i);
    stop_req_i <= !self_e;
    data_tag <= dt;
    hardware_transfer_flag_i <= flag;
    self_end <= self_e;
    dly <= d;
    stat <= s;
    transfer_start_i <= 1'b1;
    go <= 1'b1;
    @(posedge clk_i);
    transfer_start_i <= 1'b0;
    go <= 1'b0;
    if (!self_e) begin
      wait_on(0, 1'b1, n);
      check(tag_out.service_out, 1'b0);
      wait_on(0, 1'b0, n);
      check(lines.service_in | lines.inbound_data_tag, 1'b0);
    end
    wait_on(1, 1'b1, n);
    check(lines.status_in_tag, 1'b1);
    wait_on(2, 1'b1, n);
    check(8'(n), 8'(STROBE_DELAY_CYC));
    exp_b = flag ? (s | CH_END) : exp_b;
    wait_on(3, 1'b1, n);
    check(reg_a, s | CH_END);
    check(reg_b, exp_b);
    check(cond, self_e ? 2'h2 : 2'h1);
    check(lines.status_in_tag, 1'b1);
    check(tag_out.command_out, 1'b0);
    check(tag_out.select_out | tag_out.retain_out_tag, 1'b0);
    wait_on(1, 1'b1, n);
    check(lines.status_in_tag, 1'b0);
    check(tag_out.service_out, 1'b1);
    wait_on(4, 1'b1, n);
    check(tag_out.service_out, 1'b0);
    check(lines.operational_in, 1'b0);
  endtask : run_ending

  task automatic scen_stop_prompt();
    run_ending(1'b0, 1'b1, 4'h0, 8'h01, 1'b0);
  endtask : scen_stop_prompt

  task automatic scen_stop_slow_no_flag();
    run_ending(1'b0, 1'b0, 4'h2, 8'h41, 1'b1);
  endtask : scen_stop_slow_no_flag

  task automatic scen_adapter_end_slow();
    run_ending(1'b1, 1'b1, 4'h3, 8'h80, 1'b0);
  endtask : scen_adapter_end_slow

  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(8'(tag_out), 8'(TAG_OUT_RST));
    scen_stop_prompt();
    scen_stop_slow_no_flag();
    scen_adapter_end_slow();
    repeat (5) @(posedge clk_i);
    close_out();
  end
endmodule : channel_stop_and_ending_sequence_tb_top
